// [gpdi_pkg.sv]
// Package: register map, fields and state codes of the bus interface block
package gpdi_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STB    = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_TXDATA = 8'h10;
  localparam logic [7:0] OFS_EVENT  = 8'h14;
  // Control register fields
  localparam int CTRL_HC_BUS   = 0;
  localparam int CTRL_HC_SAME  = 1;
  localparam int CTRL_SRQ      = 2;
  localparam int CTRL_BUSY     = 3;
  // Transmit data fields
  localparam int TX_EOI        = 8;
  // Event (write-only) fields
  localparam int EV_HC_KEY     = 0;
  localparam int EV_LOCAL_KEY  = 1;
  localparam int EV_RX_POP     = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0]  STB_RST  = 8'h00;
  // Message available bit of the status byte
  localparam int STB_MAV       = 4;
  // Remote/local states, Gray along local->remote->lockout
  typedef enum logic [1:0] {
    GPDI_LOCAL   = 2'b00,
    GPDI_REMOTE  = 2'b01,
    GPDI_LOCKOUT = 2'b11
  } gpdi_rl_t;
  // Bus roles, Gray along idle->listen->talk->talk-only
  typedef enum logic [1:0] {
    GPDI_IDLE   = 2'b00,
    GPDI_LISTEN = 2'b01,
    GPDI_TALK   = 2'b11,
    GPDI_TONLY  = 2'b10
  } gpdi_role_t;
endpackage : gpdi_pkg

// [gpdi_top.sv]
// Module: instrument-side interface of the general purpose parallel bus
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Overview of operation
// - Any received command enters talk/listen operation; code enters listen or talk only on its own listen or talk address
// - Messages end with EOI on final byte
// - Hardcopy key with bus destination: talk-only
// - Talk-only: sole talker, no controller assumed
// - Bus hardcopy command queues response until talk
// - Device can assert service request line
// - Serial poll enable then talk returns status
// - After poll byte, drop request, clear status
// - Trigger applied after prior commands finish
// - Interface clear unaddresses, idles until readdressed
// - Selective clear needs listen; universal does not
// - Device clear empties buffers, clears available bit
// - Power-up in local state
// - Messages processed in local and remote
// - Command with remote enable enters remote
// - Local key in remote returns to local
// - Lockout command disables all panel controls
// - Lockout left by go-local or readdress without enable
// - Same-port hardcopy answered as query response
// ---------------------------------------------------------------------------
module gpdi_top #(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  input  wire logic        pclk,           // System clock
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic [7:0]  dio_i,          // Data lines in
  input  wire logic        eoi_i,          // End line in
  input  wire logic        atn_i,          // Attention in
  input  wire logic        ren_i,          // Remote enable in
  input  wire logic        ifc_i,          // Interface clear in
  input  wire logic        dav_i,          // Data valid in
  input  wire logic        nrfd_i,         // Not ready for data in
  input  wire logic        ndac_i,         // Not accepted in
  input  wire logic [4:0]  my_addr,        // Primary address
  output logic      [7:0]  dio_o,          // Data lines out
  output logic             dio_oe_n,       // Data lines enable, low drive
  output logic             eoi_o,          // End line out
  output logic             dav_o,          // Data valid out
  output logic             nrfd_o,         // Not ready out
  output logic             ndac_o,         // Not accepted out
  output logic             srq_o,          // Service request out
  output logic             trig_o,         // Waveform trigger pulse
  output logic             panel_en,       // Panel controls enabled
  output logic             local_key_en,   // Local key enabled
  output logic             cmd_ready       // Command waiting for firmware
);

  localparam int RXW = $clog2(RX_DEPTH);
  localparam int TXW = $clog2(TX_DEPTH);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  s_dav, s_eoi, s_atn, s_ren, s_ifc, s_nrfd, s_ndac;
    logic [15:0] s_dio;
    logic [31:0] ctrl;
    logic [7:0]  stb;
    gpdi_pkg::gpdi_rl_t   rl;
    gpdi_pkg::gpdi_role_t role;
    logic        spe, spoll_sent, trig_pend, dav_seen;
    logic        addressed_once;
    logic [RXW:0] rx_cnt, cmd_len;
    logic [RXW-1:0] rx_wr, rx_rd;
    logic [TXW:0] tx_cnt;
    logic [TXW-1:0] tx_wr, tx_rd;
    logic        hc_pend;
    logic [1:0]  tx_ph;
    logic [31:0] prdata;
    logic        pready;
    logic [7:0]  dio;
    logic        dio_oe_n, eoi, dav, nrfd, ndac, srq, trig;
  } gpdi_st_t;

  gpdi_st_t st_r, st_nxt;
  logic [7:0] rx_mem [RX_DEPTH];
  logic [8:0] tx_mem [TX_DEPTH];
  logic       rx_we, tx_we;
  logic [8:0] tx_wdata;

  function automatic logic is_acc(input logic s, input logic e);
    return s & e;
  endfunction

  wire logic       dav_q  = st_r.s_dav[1];
  wire logic       atn_q  = st_r.s_atn[1];
  wire logic       ren_q  = st_r.s_ren[1];
  wire logic       ifc_q  = st_r.s_ifc[1];
  wire logic       eoi_q  = st_r.s_eoi[1];
  wire logic [7:0] dio_q  = st_r.s_dio[15:8];
  wire logic       acc    = is_acc(psel, penable);
  // Writes land only at the edge where ready is seen high
  wire logic       wr_acc = acc & pwrite & st_r.pready;
  wire logic       rd_acc = acc & ~pwrite & ~st_r.pready;

  always_ff @(posedge pclk) begin
    if (rx_we) begin
      rx_mem[st_r.rx_wr] <= dio_q;
    end
    if (tx_we) begin
      tx_mem[st_r.tx_wr] <= tx_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic new_byte, listen_ok, is_cmd, dcl, hc_key, loc_key, pop;
    logic [7:0] b;
    st_nxt   = st_r;
    rx_we    = 1'b0;
    tx_we    = 1'b0;
    tx_wdata = pwdata[8:0];
    // Two-stage synchronisers on all bus input pins
    st_nxt.s_dav  = {st_r.s_dav[0], dav_i};
    st_nxt.s_eoi  = {st_r.s_eoi[0], eoi_i};
    st_nxt.s_atn  = {st_r.s_atn[0], atn_i};
    st_nxt.s_ren  = {st_r.s_ren[0], ren_i};
    st_nxt.s_ifc  = {st_r.s_ifc[0], ifc_i};
    st_nxt.s_nrfd = {st_r.s_nrfd[0], nrfd_i};
    st_nxt.s_ndac = {st_r.s_ndac[0], ndac_i};
    st_nxt.s_dio  = {st_r.s_dio[7:0], dio_i};
    st_nxt.trig   = 1'b0;
    st_nxt.pready = 1'b0;
    b        = dio_q;
    new_byte = dav_q & ~st_r.dav_seen;
    st_nxt.dav_seen = dav_q;
    listen_ok = (st_r.role == gpdi_pkg::GPDI_LISTEN);
    is_cmd   = 1'b0;
    dcl      = 1'b0;
    hc_key   = wr_acc && paddr == gpdi_pkg::OFS_EVENT
               && pwdata[gpdi_pkg::EV_HC_KEY];
    loc_key  = wr_acc && paddr == gpdi_pkg::OFS_EVENT
               && pwdata[gpdi_pkg::EV_LOCAL_KEY];
    pop      = wr_acc && paddr == gpdi_pkg::OFS_EVENT
               && pwdata[gpdi_pkg::EV_RX_POP];

    // Interface messages under attention
    if (new_byte && atn_q) begin
      if (b == {3'b001, my_addr}) begin
        st_nxt.role = gpdi_pkg::GPDI_LISTEN;
        st_nxt.addressed_once = 1'b1;
        if (!ren_q) begin
          st_nxt.rl = gpdi_pkg::GPDI_LOCAL;
        end
      end else if (b == {3'b010, my_addr}) begin
        st_nxt.role = gpdi_pkg::GPDI_TALK;
        if (!ren_q) begin
          st_nxt.rl = gpdi_pkg::GPDI_LOCAL;
        end
      end else if (b == 8'h3F || b == 8'h5F) begin
        if (st_r.role != gpdi_pkg::GPDI_TONLY) begin
          st_nxt.role = gpdi_pkg::GPDI_IDLE;
        end
      end else if (b == 8'h18) begin
        st_nxt.spe = 1'b1;
      end else if (b == 8'h19) begin
        st_nxt.spe = 1'b0;
      end else if (b == 8'h14) begin
        dcl = 1'b1;
      end else if (b == 8'h04 && listen_ok) begin
        dcl = 1'b1;
      end else if (b == 8'h08 && listen_ok) begin
        st_nxt.trig_pend = 1'b1;
      end else if (b == 8'h11) begin
        st_nxt.rl = gpdi_pkg::GPDI_LOCKOUT;
      end else if (b == 8'h01 && listen_ok) begin
        st_nxt.rl = gpdi_pkg::GPDI_LOCAL;
      end
    end

    // Device-dependent bytes into the input buffer
    if (new_byte && !atn_q && listen_ok
        && st_r.rx_cnt < (RXW+1)'(RX_DEPTH)) begin
      rx_we = 1'b1;
      st_nxt.rx_wr  = st_r.rx_wr + 1'b1;
      st_nxt.rx_cnt = st_r.rx_cnt + 1'b1;
      if (eoi_q) begin
        st_nxt.cmd_len = st_r.rx_cnt + 1'b1;
        is_cmd = 1'b1;
      end
    end
    if (is_cmd) begin
      if (ren_q && st_r.rl == gpdi_pkg::GPDI_LOCAL) begin
        st_nxt.rl = gpdi_pkg::GPDI_REMOTE;
      end
    end
    if (loc_key && st_r.rl == gpdi_pkg::GPDI_REMOTE) begin
      st_nxt.rl = gpdi_pkg::GPDI_LOCAL;
    end

    // Firmware pops received bytes
    if (pop && st_r.rx_cnt != '0 && !is_cmd) begin
      st_nxt.rx_rd  = st_r.rx_rd + 1'b1;
      st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
      if (st_r.cmd_len != '0) begin
        st_nxt.cmd_len = st_r.cmd_len - 1'b1;
      end
    end

    // Trigger waits for command processing to finish
    if (st_r.trig_pend && st_r.cmd_len == '0
        && !st_r.ctrl[gpdi_pkg::CTRL_BUSY]) begin
      st_nxt.trig = 1'b1;
      // A new trigger message in the same cycle stays pending
      if (!(new_byte && atn_q && b == 8'h08 && listen_ok)) begin
        st_nxt.trig_pend = 1'b0;
      end
    end

    // Hardcopy key: talk-only when bus is destination
    if (hc_key && st_r.ctrl[gpdi_pkg::CTRL_HC_BUS]) begin
      st_nxt.role = gpdi_pkg::GPDI_TONLY;
    end

    // Transmit queue fill; hardcopy flagged as pending response
    if (wr_acc && paddr == gpdi_pkg::OFS_TXDATA
        && st_r.tx_cnt < (TXW+1)'(TX_DEPTH)) begin
      tx_we = 1'b1;
      st_nxt.tx_wr  = st_r.tx_wr + 1'b1;
      st_nxt.tx_cnt = st_r.tx_cnt + 1'b1;
      if (st_r.ctrl[gpdi_pkg::CTRL_HC_SAME]) begin
        st_nxt.hc_pend = 1'b1;
      end
    end

    // Source handshake: talker or talk-only
    case (st_r.tx_ph)
      2'd0: begin
        st_nxt.dio_oe_n = 1'b1;
        st_nxt.dav = 1'b0;
        st_nxt.eoi = 1'b0;
        if (!atn_q && st_r.role == gpdi_pkg::GPDI_TALK && st_r.spe) begin
          st_nxt.dio = {1'b0, st_r.srq, st_r.stb[5:0]};
          st_nxt.eoi = 1'b1;
          st_nxt.dio_oe_n = 1'b0;
          st_nxt.spoll_sent = 1'b1;
          st_nxt.tx_ph = 2'd1;
        end else if ((st_r.role == gpdi_pkg::GPDI_TALK && !atn_q
                      || st_r.role == gpdi_pkg::GPDI_TONLY)
                     && st_r.tx_cnt != '0) begin
          st_nxt.dio = tx_mem[st_r.tx_rd][7:0];
          st_nxt.eoi = tx_mem[st_r.tx_rd][gpdi_pkg::TX_EOI];
          st_nxt.dio_oe_n = 1'b0;
          st_nxt.spoll_sent = 1'b0;
          st_nxt.tx_ph = 2'd1;
        end
      end
      2'd1: begin
        if (!st_r.s_nrfd[1]) begin
          st_nxt.dav = 1'b1;
          st_nxt.tx_ph = 2'd2;
        end
      end
      2'd2: begin
        if (!st_r.s_ndac[1]) begin
          st_nxt.dav = 1'b0;
          st_nxt.tx_ph = 2'd0;
          if (st_r.spoll_sent) begin
            st_nxt.stb = gpdi_pkg::STB_RST;
            st_nxt.ctrl[gpdi_pkg::CTRL_SRQ] = 1'b0;
          end else begin
            st_nxt.tx_rd  = st_r.tx_rd + 1'b1;
            st_nxt.tx_cnt = st_nxt.tx_cnt - 1'b1;
            if (st_r.eoi) begin
              if (!tx_we) begin
                st_nxt.hc_pend = 1'b0;
              end
              if (st_r.role == gpdi_pkg::GPDI_TONLY) begin
                st_nxt.role = gpdi_pkg::GPDI_IDLE;
              end
            end
          end
        end
      end
      default: st_nxt.tx_ph = 2'd0;
    endcase

    // Talker lets go of the lines while the controller holds attention
    if (atn_q && st_r.role != gpdi_pkg::GPDI_TONLY) begin
      st_nxt.tx_ph    = 2'd0;
      st_nxt.dav      = 1'b0;
      st_nxt.eoi      = 1'b0;
      st_nxt.dio_oe_n = 1'b1;
    end

    // Acceptor handshake when listening; NDAC also for command bytes under attention
    st_nxt.nrfd = listen_ok && !atn_q
                  && st_r.rx_cnt >= (RXW+1)'(RX_DEPTH);
    st_nxt.ndac = (listen_ok || atn_q) && !dav_q;

    // Register writes
    if (wr_acc && paddr == gpdi_pkg::OFS_CTRL) begin
      st_nxt.ctrl = pwdata;
    end
    if (wr_acc && paddr == gpdi_pkg::OFS_STB) begin
      st_nxt.stb = pwdata[7:0];
    end
    st_nxt.srq = st_nxt.ctrl[gpdi_pkg::CTRL_SRQ];
    st_nxt.stb[gpdi_pkg::STB_MAV] = (st_nxt.tx_cnt != '0);

    // Device clear
    if (dcl) begin
      st_nxt.rx_cnt = '0;
      st_nxt.rx_rd  = st_r.rx_wr;
      st_nxt.cmd_len = '0;
      st_nxt.tx_cnt = '0;
      st_nxt.tx_rd  = st_nxt.tx_wr;
      st_nxt.hc_pend = 1'b0;
      st_nxt.stb[gpdi_pkg::STB_MAV] = 1'b0;
      st_nxt.tx_ph  = 2'd0;
      st_nxt.dav = 1'b0;
      st_nxt.dio_oe_n = 1'b1;
    end

    // Interface clear overrides all bus roles
    if (ifc_q) begin
      st_nxt.role = gpdi_pkg::GPDI_IDLE;
      st_nxt.spe  = 1'b0;
      st_nxt.tx_ph = 2'd0;
      st_nxt.dav  = 1'b0;
      st_nxt.eoi  = 1'b0;
      st_nxt.dio_oe_n = 1'b1;
      st_nxt.nrfd = 1'b0;
      st_nxt.ndac = 1'b0;
    end

    // Read mux
    if (rd_acc) begin
      unique case (paddr)
        gpdi_pkg::OFS_CTRL:   st_nxt.prdata = st_r.ctrl;
        gpdi_pkg::OFS_STATUS: st_nxt.prdata = {16'h0000,
          3'(st_r.rx_cnt), 3'(st_r.tx_cnt), st_r.hc_pend, st_r.spe,
          st_r.rl, st_r.role, (st_r.cmd_len != '0), st_r.trig_pend,
          st_r.srq, ren_q};
        gpdi_pkg::OFS_STB:    st_nxt.prdata = {24'h0000_00, st_r.stb};
        gpdi_pkg::OFS_RXDATA: st_nxt.prdata = {24'h0000_00,
                                               rx_mem[st_r.rx_rd]};
        default:              st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    st_nxt.pready = acc & ~st_r.pready;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ctrl <= gpdi_pkg::CTRL_RST;
      st_r.rl <= gpdi_pkg::GPDI_LOCAL;
      st_r.role <= gpdi_pkg::GPDI_IDLE;
      st_r.dio_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata       = st_r.prdata;
  assign pready       = st_r.pready;
  assign pslverr      = 1'b0;
  assign dio_o        = st_r.dio;
  assign dio_oe_n     = st_r.dio_oe_n;
  assign eoi_o        = st_r.eoi;
  assign dav_o        = st_r.dav;
  assign nrfd_o       = st_r.nrfd;
  assign ndac_o       = st_r.ndac;
  assign srq_o        = st_r.srq;
  assign trig_o       = st_r.trig;
  assign cmd_ready    = st_r.cmd_len != '0;
  assign panel_en     = st_r.rl == gpdi_pkg::GPDI_LOCAL;
  assign local_key_en = st_r.rl != gpdi_pkg::GPDI_LOCKOUT;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_IFC: assert property (@(posedge pclk) disable iff (!presetn)
    ifc_q |=> st_r.role == gpdi_pkg::GPDI_IDLE && st_r.dio_oe_n)
    else $error("Interface clear did not idle the port");
  AST_POLL: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.tx_ph == 2'd2 && st_r.spoll_sent && !st_r.s_ndac[1]
    |=> st_r.stb[5:0] == 6'h00 || $past(wr_acc))
    else $error("Status byte not cleared after poll");
  AST_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.trig |-> $past(st_r.cmd_len) == '0)
    else $error("Trigger fired with command pending");
  AST_LOCKOUT: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.rl == gpdi_pkg::GPDI_LOCKOUT |-> !local_key_en && !panel_en)
    else $error("Panel active in lockout");
  AST_SRQ: assert property (@(posedge pclk) disable iff (!presetn)
    srq_o |-> $past(st_nxt.ctrl[gpdi_pkg::CTRL_SRQ]))
    else $error("Service request without cause");
  AST_EOI: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd_ready) |-> $past(eoi_q))
    else $error("Command released without end byte");
  logic hc_chk;
  assign hc_chk = wr_acc && paddr == gpdi_pkg::OFS_EVENT
                  && pwdata[gpdi_pkg::EV_HC_KEY]
                  && st_r.ctrl[gpdi_pkg::CTRL_HC_BUS];
  AST_TONLY: assert property (@(posedge pclk) disable iff (!presetn)
    hc_chk |=> st_r.role == gpdi_pkg::GPDI_TONLY || $past(ifc_q))
    else $error("Hardcopy key did not start talk-only");
  AST_PWRUP: assert property (@(posedge pclk)
    $rose(presetn) |-> st_r.rl == gpdi_pkg::GPDI_LOCAL)
    else $error("Not local after reset");

endmodule : gpdi_top
`default_nettype wire

// [gpdi_ctl_model.sv]
// Bus controller and listen-only printer model facing the device
`timescale 1ns/1ps
`default_nettype none
module gpdi_ctl_model (
  input  wire logic       pclk,    // System clock
  input  wire logic [7:0] dio_o,   // Device data out
  input  wire logic       eoi_o,   // Device end out
  input  wire logic       dav_o,   // Device data valid
  input  wire logic       nrfd_o,  // Device not ready
  input  wire logic       ndac_o,  // Device not accepted
  output logic      [7:0] ctl_dio, // Model data drive
  output logic            eoi_i,   // End line
  output logic            atn_i,   // Attention line
  output logic            dav_i,   // Data valid
  output logic            nrfd_i,  // Not ready for data
  output logic            ndac_i   // Not accepted
);
  initial begin
    ctl_dio = 8'h00;
    eoi_i   = 1'b0;
    atn_i   = 1'b0;
    dav_i   = 1'b0;
    nrfd_i  = 1'b1;
    ndac_i  = 1'b1;
  end
  // ---------------------------------------------------------------------
  // Source and acceptor handshakes
  // ---------------------------------------------------------------------
  task automatic send(input logic atn, input logic eoi, input logic [7:0] d);
    int n;
    @(posedge pclk);
    ctl_dio <= d;
    eoi_i   <= eoi;
    atn_i   <= atn;
    repeat (4) @(posedge pclk);
    for (n = 0; n < 200 && nrfd_o !== 1'b0; n++) @(posedge pclk);
    dav_i <= 1'b1;
    repeat (6) @(posedge pclk);
    for (n = 0; n < 200 && ndac_o !== 1'b0; n++) @(posedge pclk);
    dav_i <= 1'b0;
    repeat (4) @(posedge pclk);
    // Released lines fall back to the pulled-up false level
    ctl_dio <= 8'h00;
    eoi_i   <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic set_atn(input logic v);
    @(posedge pclk);
    atn_i <= v;
  endtask
  // Listens without being addressed, as a printer would
  task automatic recv(output logic [7:0] d, output logic e);
    int n;
    @(posedge pclk);
    atn_i  <= 1'b0;
    nrfd_i <= 1'b0;
    for (n = 0; n < 400 && dav_o !== 1'b1; n++) @(posedge pclk);
    d = dio_o;
    e = eoi_o;
    nrfd_i <= 1'b1;
    ndac_i <= 1'b0;
    for (n = 0; n < 400 && dav_o !== 1'b0; n++) @(posedge pclk);
    ndac_i <= 1'b1;
  endtask
endmodule // gpdi_ctl_model
`default_nettype wire

// [tb_top.sv]
// Testbench for the instrument-side bus interface block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] LSN = 8'h25;
  localparam logic [7:0] TLK = 8'h45;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [7:0]  paddr, ctl_dio, dio_o, d;
  logic [31:0] pwdata, prdata;
  logic        eoi_i, atn_i, ren_i, ifc_i, dav_i, nrfd_i, ndac_i, e;
  logic        dio_oe_n, eoi_o, dav_o, nrfd_o, ndac_o, srq_o, trig_o;
  logic        panel_en, local_key_en, cmd_ready;
  wire  [7:0]  dio_i;
  int          n_errors, compares, n_trig;
  // Wired data lines: any party driving true wins
  assign dio_i = ctl_dio | (dio_oe_n ? 8'h00 : dio_o);
  gpdi_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dio_i(dio_i),
    .eoi_i(eoi_i), .atn_i(atn_i), .ren_i(ren_i), .ifc_i(ifc_i),
    .dav_i(dav_i), .nrfd_i(nrfd_i), .ndac_i(ndac_i), .my_addr(5'h05),
    .dio_o(dio_o), .dio_oe_n(dio_oe_n), .eoi_o(eoi_o), .dav_o(dav_o),
    .nrfd_o(nrfd_o), .ndac_o(ndac_o), .srq_o(srq_o), .trig_o(trig_o),
    .panel_en(panel_en), .local_key_en(local_key_en),
    .cmd_ready(cmd_ready));
  gpdi_ctl_model m (.pclk(pclk), .dio_o(dio_o), .eoi_o(eoi_o),
    .dav_o(dav_o), .nrfd_o(nrfd_o), .ndac_o(ndac_o), .ctl_dio(ctl_dio),
    .eoi_i(eoi_i), .atn_i(atn_i), .dav_i(dav_i), .nrfd_i(nrfd_i),
    .ndac_i(ndac_i));
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    if (trig_o === 1'b1) n_trig++;
  end
  // ---------------------------------------------------------------------
  // Access and comparison tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) chk(32'(pready), 32'h0000_0001);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    apb(1'b1, a, v, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] mk,
                     input logic [31:0] exp);
    logic [31:0] x;
    apb(1'b0, a, 32'h0000_0000, x);
    chk(x & mk, exp);
  endtask
  task automatic cmd(input logic [7:0] b);
    m.send(1'b1, 1'b0, b);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    give_verdict();
  end
  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, ren_i, ifc_i} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    wt(16);
    presetn <= 1'b1;
    wt(1);
    chk(32'(dio_oe_n), 1);
    chk(32'({panel_en, local_key_en, srq_o}), 32'h6);
    tend("reset");
    ren_i <= 1'b1;
    cmd(LSN);
    m.send(1'b0, 1'b0, 8'h41);
    chk(32'(cmd_ready), 0);
    m.send(1'b0, 1'b1, 8'h42);
    chk(32'(cmd_ready), 1);
    chk(32'({panel_en, local_key_en}), 1);
    rdc(gpdi_pkg::OFS_RXDATA, 32'h0000_00ff, 32'h0000_0041);
    wr(gpdi_pkg::OFS_EVENT, 32'h0000_0004);
    rdc(gpdi_pkg::OFS_RXDATA, 32'h0000_00ff, 32'h0000_0042);
    wr(gpdi_pkg::OFS_EVENT, 32'h0000_0002);
    wt(4);
    chk(32'(panel_en), 1);
    tend("remote");
    m.send(1'b0, 1'b1, 8'h43);
    cmd(8'h11);
    chk(32'({panel_en, local_key_en}), 0);
    wr(gpdi_pkg::OFS_EVENT, 32'h0000_0002);
    wt(4);
    chk(32'(panel_en), 0);
    cmd(LSN);
    cmd(8'h01);
    chk(32'({panel_en, local_key_en}), 3);
    m.send(1'b0, 1'b1, 8'h44);
    cmd(8'h11);
    ren_i <= 1'b0;
    cmd(8'h3F);
    cmd(LSN);
    chk(32'(panel_en), 1);
    tend("lockout");
    cmd(8'h3F);
    cmd(8'h14);
    chk(32'(cmd_ready), 0);
    cmd(LSN);
    m.send(1'b0, 1'b1, 8'h5A);
    chk(32'({cmd_ready, panel_en}), 3);
    rdc(gpdi_pkg::OFS_RXDATA, 32'h0000_00ff, 32'h0000_005a);
    wr(gpdi_pkg::OFS_TXDATA, 32'h0000_0133);
    cmd(8'h3F);
    cmd(8'h04);
    chk(32'(cmd_ready), 1);
    cmd(LSN);
    cmd(8'h04);
    chk(32'(cmd_ready), 0);
    rdc(gpdi_pkg::OFS_STB, 32'h0000_0010, 32'h0000_0000);
    tend("clear");
    wr(gpdi_pkg::OFS_STB, 32'h0000_0001);
    wr(gpdi_pkg::OFS_CTRL, 32'h0000_0004);
    wt(4);
    chk(32'(srq_o), 1);
    cmd(8'h18);
    cmd(TLK);
    m.recv(d, e);
    chk(32'(d & 8'hbf), 32'h0000_0001);
    wt(4);
    chk(32'(srq_o), 0);
    rdc(gpdi_pkg::OFS_STB, 32'h0000_00ff, 32'h0000_0000);
    cmd(8'h19);
    cmd(8'h5F);
    tend("poll");
    wr(gpdi_pkg::OFS_CTRL, 32'h0000_0003);
    wr(gpdi_pkg::OFS_TXDATA, 32'h0000_0055);
    wr(gpdi_pkg::OFS_TXDATA, 32'h0000_01aa);
    rdc(gpdi_pkg::OFS_STB, 32'h0000_0010, 32'h0000_0010);
    chk(32'(dio_oe_n), 1);
    cmd(TLK);
    m.recv(d, e);
    chk(32'({e, d}), 32'h0000_0055);
    m.recv(d, e);
    chk(32'({e, d}), 32'h0000_01aa);
    cmd(8'h5F);
    tend("query hardcopy");
    wr(gpdi_pkg::OFS_CTRL, 32'h0000_0008);
    cmd(LSN);
    cmd(8'h08);
    wt(40);
    chk(n_trig, 0);
    wr(gpdi_pkg::OFS_CTRL, 32'h0000_0000);
    wt(20);
    chk(n_trig, 1);
    tend("trigger");
    cmd(8'h3F);
    wr(gpdi_pkg::OFS_CTRL, 32'h0000_0001);
    wr(gpdi_pkg::OFS_EVENT, 32'h0000_0001);
    wr(gpdi_pkg::OFS_TXDATA, 32'h0000_015a);
    m.recv(d, e);
    chk(32'({e, d}), 32'h0000_015a);
    tend("talk only");
    cmd(TLK);
    wr(gpdi_pkg::OFS_TXDATA, 32'h0000_0177);
    m.set_atn(1'b0);
    wt(8);
    chk(32'(dio_oe_n), 0);
    ifc_i <= 1'b1;
    wt(8);
    ifc_i <= 1'b0;
    wt(20);
    chk(32'({dio_oe_n, dav_o}), 2);
    tend("interface clear");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
